// file: rtl/ivm_top.sv
// ivm_top: maps peripheral request lines to a vector, offset and attributes
// assumes: requests are synchronous levels held until serviced
// Functional notes
// R1: offset equals 0x3fc minus four times vector
// R2: priority index equals vector for 12..143
// R3: converter requests at 139, 140, not dma-clearable
// R4: flash bank a at vector 133, offset 0x1e8
// R5: pulse channels 0..3 at vectors 38..41, clearable
// R6: capture 0,1,4,5 at 65,66,69,70, clearable
// R7: reserved never raised; vectors 0..11 fixed
`timescale 1ns/1ps
module ivm_top
(
	input  wire logic            clk,
	input  wire logic            arst_n,
	input  wire ivm_pkg::ivm_req_t req,
	output ivm_pkg::ivm_vec_t    vec_out
);

	// ************************************************************
	// source table
	// ************************************************************
	// flat request vector, lowest index wins
	logic [ivm_pkg::N_SRC-1:0] src;          // request bits
	logic [7:0]                src_vec [ivm_pkg::N_SRC]; // vector of each

	assign src = {req.converter_pulse_detect_request,
	              req.converter_range_compare_request,
	              req.flash_bank_a_request,
	              req.capture_channel5_request,
	              req.capture_channel4_request,
	              req.capture_channel1_request,
	              req.capture_channel0_request,
	              req.pulse_gen_request};

	// pulse channels sit on consecutive vectors
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_pulse
			assign src_vec[g] = ivm_pkg::VEC_PULSE0 + 8'(g); // [R5]
		end
	endgenerate
	assign src_vec[4]  = ivm_pkg::VEC_CAP0;   // [R6]
	assign src_vec[5]  = ivm_pkg::VEC_CAP1;   // [R6]
	assign src_vec[6]  = ivm_pkg::VEC_CAP4;   // [R6]
	assign src_vec[7]  = ivm_pkg::VEC_CAP5;   // [R6]
	assign src_vec[8]  = ivm_pkg::VEC_FLASH_A; // [R4]
	assign src_vec[9]  = ivm_pkg::VEC_RANGE;  // [R3]
	assign src_vec[10] = ivm_pkg::VEC_PDET;   // [R3]

	// ************************************************************
	// helpers
	// ************************************************************
	// table offset of a vector; descends by four per entry
	function automatic logic [9:0] ofs_of(input logic [7:0] v);
		return ivm_pkg::OFS_TOP - 10'({v, 2'b00}); // [R1]
	endfunction : ofs_of

	// ************************************************************
	// selection
	// ************************************************************
	// fixed priority: lower vector number first, matching source order
	logic       sel_valid; // any request
	logic [7:0] sel_vec;   // chosen vector
	always_comb
	begin
		sel_valid = 1'b0;
		sel_vec   = 8'h00;
		for (int i = ivm_pkg::N_SRC - 1; i >= 0; i--)
			if (src[i])
			begin
				sel_valid = 1'b1;
				sel_vec   = src_vec[i];
			end
	end

	// attribute lookup, one cycle latency, so the vector stage is aligned
	logic [1:0] attr;      // dma clearable, has source
	ivm_attr_rom u_rom
	(
		.clk    (clk),
		.arst_n (arst_n),
		.addr   (sel_vec),
		.rdata  (attr)
	);

	// ************************************************************
	// first stage: latch selection
	// ************************************************************
	logic       v1_q;   // valid in stage one
	logic [7:0] vec1_q; // vector in stage one
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			v1_q   <= 1'b0;
			vec1_q <= 8'h00;
		end
		else
		begin
			v1_q   <= sel_valid;
			vec1_q <= sel_vec;
		end
	end

	// ************************************************************
	// output stage
	// ************************************************************
	// a vector without a source is never raised, guarding reserved slots
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			vec_out <= '0;
		else
		begin
			vec_out.valid      <= v1_q && attr[0];  // [R7]
			vec_out.vec        <= vec1_q;
			vec_out.ofs        <= ofs_of(vec1_q);   // [R1]
			// fixed vectors 0..11 carry no slot and no dma clear
			vec_out.prio_slot  <= (vec1_q >= ivm_pkg::PRIO_FIRST); // [R2]
			vec_out.prio_index <= (vec1_q >= ivm_pkg::PRIO_FIRST)
			                      ? vec1_q : 8'h00; // [R2]
			vec_out.dma_clear  <= attr[1] &&
			                      (vec1_q > ivm_pkg::FIXED_LAST); // [R7]
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	// all checks run on the system clock and rest while reset is low
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// flash line alone
	sequence s_flash_only;
		req == ivm_pkg::ivm_req_t'(11'h004);
	endsequence

	// the first edge after release still shows the cleared output stage
	a_offset_formula: assert property ( // [R1]
		$past(arst_n) |->
		vec_out.ofs == 10'(10'h3fc - 10'({vec_out.vec, 2'b00})))
		else $error("offset not derived from vector");
	a_prio_index: assert property ( // [R2]
		vec_out.valid |-> vec_out.prio_slot &&
		vec_out.prio_index == vec_out.vec)
		else $error("priority index differs from vector");
	a_conv_route: assert property ( // [R3]
		req == ivm_pkg::ivm_req_t'(11'h002) |-> ##2
		vec_out.valid && vec_out.vec == 8'd139 && !vec_out.dma_clear)
		else $error("range compare misrouted");
	a_pdet_route: assert property ( // [R3]
		req == ivm_pkg::ivm_req_t'(11'h001) |-> ##2
		vec_out.valid && vec_out.vec == 8'd140 &&
		!vec_out.dma_clear)
		else $error("pulse detect misrouted");
	a_flash_route: assert property ( // [R4]
		s_flash_only |-> ##2 vec_out.valid && vec_out.vec == 8'd133 &&
		vec_out.ofs == 10'h1e8 && vec_out.dma_clear)
		else $error("flash bank a misrouted");
	a_pulse_route: assert property ( // [R5]
		req == ivm_pkg::ivm_req_t'(11'h200) |-> ##2
		vec_out.vec == 8'd40 && vec_out.dma_clear)
		else $error("pulse channel 2 misrouted");
	a_cap_route: assert property ( // [R6]
		req == ivm_pkg::ivm_req_t'(11'h010) |-> ##2
		vec_out.vec == 8'd69 && vec_out.dma_clear)
		else $error("capture channel 4 misrouted");
	a_idle_quiet: assert property ( // [R7]
		req == '0 ##1 req == '0 |=> !vec_out.valid)
		else $error("vector raised without a request");
	a_no_fixed: assert property ( // [R7]
		vec_out.valid |-> vec_out.vec > ivm_pkg::FIXED_LAST &&
		vec_out.vec <= ivm_pkg::VEC_LAST)
		else $error("fixed or out-of-range vector raised");

	// every other mapped line, each alone, two edges after it is taken
	a_pulse0_route: assert property ( // [R5]
		req == ivm_pkg::ivm_req_t'(11'h080) |-> ##2
		vec_out.valid && vec_out.vec == 8'd38 && vec_out.dma_clear)
		else $error("pulse channel 0 misrouted");
	a_pulse1_route: assert property ( // [R5]
		req == ivm_pkg::ivm_req_t'(11'h100) |-> ##2
		vec_out.valid && vec_out.vec == 8'd39 && vec_out.dma_clear)
		else $error("pulse channel 1 misrouted");
	a_pulse3_route: assert property ( // [R5]
		req == ivm_pkg::ivm_req_t'(11'h400) |-> ##2
		vec_out.valid && vec_out.vec == 8'd41 && vec_out.dma_clear)
		else $error("pulse channel 3 misrouted");
	a_cap0_route: assert property ( // [R6]
		req == ivm_pkg::ivm_req_t'(11'h040) |-> ##2
		vec_out.valid && vec_out.vec == 8'd65 && vec_out.dma_clear)
		else $error("capture channel 0 misrouted");
	a_cap1_route: assert property ( // [R6]
		req == ivm_pkg::ivm_req_t'(11'h020) |-> ##2
		vec_out.valid && vec_out.vec == 8'd66 && vec_out.dma_clear)
		else $error("capture channel 1 misrouted");
	a_cap5_route: assert property ( // [R6]
		req == ivm_pkg::ivm_req_t'(11'h008) |-> ##2
		vec_out.valid && vec_out.vec == 8'd70 && vec_out.dma_clear)
		else $error("capture channel 5 misrouted");

	// every line at once: the lowest vector is offered
	sequence s_all_lines;
		req == ivm_pkg::ivm_req_t'(11'h7ff);
	endsequence

	a_lowest_wins: assert property ( // [R5]
		s_all_lines |-> ##2 vec_out.valid && vec_out.vec == 8'd38)
		else $error("lowest vector did not win");

	// converter vectors never go out as dma-clearable
	a_conv_no_dma: assert property ( // [R3]
		vec_out.valid && vec_out.vec >= ivm_pkg::VEC_RANGE |->
		!vec_out.dma_clear)
		else $error("converter vector marked dma-clearable");

	// fixed vectors carry neither a dma clear nor a priority slot
	a_fixed_plain: assert property ( // [R7]
		vec_out.dma_clear || vec_out.prio_slot |->
		vec_out.vec > ivm_pkg::FIXED_LAST)
		else $error("fixed vector marked clearable or programmable");

endmodule : ivm_top

// file: rtl/ivm_pkg.sv
// ivm_pkg: constants and carrier types for the interrupt vector mapper
// assumes: one clock domain, request lines are synchronous levels
package ivm_pkg;

	// ************************************************************
	// table geometry
	// ************************************************************
	localparam int unsigned VEC_COUNT   = 144;     // vectors 0..143
	localparam int unsigned VEC_W       = 8;       // vector number width
	localparam int unsigned OFS_W       = 10;      // table offset width
	localparam logic [9:0]  OFS_TOP     = 10'h3fc; // offset of vector 0
	localparam logic [9:0]  OFS_STEP    = 10'h004; // bytes per entry
	localparam logic [7:0]  PRIO_FIRST  = 8'h0c;   // first programmable slot
	localparam logic [7:0]  VEC_LAST    = 8'h8f;   // vector 143
	localparam logic [7:0]  FIXED_LAST  = 8'h0b;   // vector 11

	// ************************************************************
	// vectors of the mapped peripheral requests
	// ************************************************************
	localparam logic [7:0]  VEC_PULSE0  = 8'h26;   // 38, channels 0..3 follow
	localparam logic [7:0]  VEC_CAP0    = 8'h41;   // 65
	localparam logic [7:0]  VEC_CAP1    = 8'h42;   // 66
	localparam logic [7:0]  VEC_CAP4    = 8'h45;   // 69
	localparam logic [7:0]  VEC_CAP5    = 8'h46;   // 70
	localparam logic [7:0]  VEC_FLASH_A = 8'h85;   // 133
	localparam logic [9:0]  OFS_FLASH_A = 10'h1e8; // its table offset
	localparam logic [7:0]  VEC_RANGE   = 8'h8b;   // 139
	localparam logic [7:0]  VEC_PDET    = 8'h8c;   // 140
	localparam int unsigned N_SRC       = 11;      // mapped request lines

	// ************************************************************
	// carriers
	// ************************************************************
	// request lines as one bundle
	typedef struct packed {
		logic [3:0] pulse_gen_request;          // channels 3..0
		logic       capture_channel0_request;
		logic       capture_channel1_request;
		logic       capture_channel4_request;
		logic       capture_channel5_request;
		logic       flash_bank_a_request;
		logic       converter_range_compare_request;
		logic       converter_pulse_detect_request;
	} ivm_req_t;

	// selected vector towards the core
	typedef struct packed {
		logic             valid;      // a request is pending
		logic [7:0]       vec;        // vector number
		logic [9:0]       ofs;        // table offset
		logic             prio_slot;  // has a priority register slot
		logic [7:0]       prio_index; // priority register index
		logic             dma_clear;  // a dma transfer may clear it
	} ivm_vec_t;

endpackage : ivm_pkg

// file: rtl/ivm_attr_rom.sv
// ivm_attr_rom: per-vector attribute table with registered read data
// assumes: address stable for one cycle, data valid the next cycle
`timescale 1ns/1ps
module ivm_attr_rom
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [7:0] addr,
	output logic      [1:0] rdata   // bit1 dma clearable, bit0 has source
);

	// ************************************************************
	// constant table
	// ************************************************************
	// only mapped sources are marked; all else reads as reserved/fixed
	function automatic logic [1:0] attr_of(input logic [7:0] v);
		logic [1:0] a;
		a = 2'h0;
		if (v >= ivm_pkg::VEC_PULSE0 && v <= ivm_pkg::VEC_PULSE0 + 8'h03)
			a = 2'h3;
		if (v == ivm_pkg::VEC_CAP0 || v == ivm_pkg::VEC_CAP1 ||
		    v == ivm_pkg::VEC_CAP4 || v == ivm_pkg::VEC_CAP5)
			a = 2'h3;
		if (v == ivm_pkg::VEC_FLASH_A)
			a = 2'h3;
		// converter compare and detect are never dma-cleared
		if (v == ivm_pkg::VEC_RANGE || v == ivm_pkg::VEC_PDET)
			a = 2'h1;
		return a;
	endfunction : attr_of

	// registered read port
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata <= 2'h0;
		else
			rdata <= attr_of(addr);
	end

endmodule : ivm_attr_rom

// file: sim/ivm_core_model.sv
// ivm_core_model: core side that turns the offered vector into a fetch
// assumes: vec_in comes registered from ivm_top in the same clock domain
`timescale 1ns/1ps
module ivm_core_model
#(
	parameter logic [23:0] TABLE_BASE = 24'h000000 // plain table base
)
(
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire ivm_pkg::ivm_vec_t vec_in,
	output logic                   fetch_en,
	output logic [23:0]            fetch_addr
);
	// ************************************************************
	// fetch stage
	// ************************************************************
	// one cycle to form the address; when idle the address toggles so
	// a stale value can never pass for a real fetch
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fetch_en   <= 1'b0;
			fetch_addr <= 24'h000000;
		end
		else
		begin
			fetch_en   <= vec_in.valid;
			fetch_addr <= vec_in.valid ? TABLE_BASE + {14'h0, vec_in.ofs}
			                           : ~fetch_addr;
		end
	end
endmodule : ivm_core_model

// file: sim/testbench.sv
// testbench: drives the request lines and judges the offered vector
// assumes: ivm_top answers two edges after a request level settles
`timescale 1ns/1ps
module testbench;
	logic              clk;        // 25 mhz system clock
	logic              arst_n;     // async reset, low active
	ivm_pkg::ivm_req_t req;        // request bundle
	ivm_pkg::ivm_vec_t vec_out;    // vector towards the core
	logic              fetch_en;   // core model fetching
	logic [23:0]       fetch_addr; // core model fetch address
	int                error_cnt;  // mismatches
	int                n_checks;   // comparisons made

	// ************************************************************
	// clock, reset, instances
	// ************************************************************
	initial clk = 1'b0;
	always #20 clk = ~clk; // 40 ns period

	ivm_top ivm_top_inst (.clk(clk), .arst_n(arst_n), .req(req),
		.vec_out(vec_out));
	ivm_core_model ivm_core_model_inst (.clk(clk), .arst_n(arst_n),
		.vec_in(vec_out), .fetch_en(fetch_en), .fetch_addr(fetch_addr));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// hold a request level, then sample once the answer has settled
	task automatic drive(input logic [10:0] bits);
		@(posedge clk);
		req <= ivm_pkg::ivm_req_t'(bits);
		repeat (3) @(posedge clk);
		#1;
	endtask : drive

	task automatic expect_vec(input logic [7:0] v, input logic dma);
		logic [9:0] ofs;
		ofs = ivm_pkg::OFS_TOP - ivm_pkg::OFS_STEP * {2'h0, v};
		check("valid", vec_out.valid, 1'b1);
		check("vec", vec_out.vec, v);
		check("ofs", vec_out.ofs, ofs);
		check("prio_slot", vec_out.prio_slot,
			v >= ivm_pkg::PRIO_FIRST);
		check("prio_index", vec_out.prio_index, v);
		check("dma_clear", vec_out.dma_clear,
			dma);
	endtask : expect_vec

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_idle();
		drive(11'h000);
		check("idle valid", vec_out.valid, 1'b0);
	endtask : t_idle

	task automatic t_pulse();
		for (int i = 0; i < 4; i++)
		begin
			drive(11'h080 << i);
			expect_vec(ivm_pkg::VEC_PULSE0 + 8'(i), 1'b1);
		end
	endtask : t_pulse

	task automatic t_capture();
		logic [7:0] cv [4];
		cv = '{ivm_pkg::VEC_CAP0, ivm_pkg::VEC_CAP1, ivm_pkg::VEC_CAP4,
			ivm_pkg::VEC_CAP5};
		for (int i = 0; i < 4; i++)
		begin
			drive(11'h040 >> i);
			expect_vec(cv[i], 1'b1);
		end
	endtask : t_capture

	// flash request, also followed into the core model's fetch
	task automatic t_flash();
		drive(11'h004);
		expect_vec(8'h85, 1'b1);
		check("flash ofs", vec_out.ofs, 10'h1e8);
		@(posedge clk);
		#1;
		check("fetch_en", fetch_en, 1'b1);
		check("fetch_addr", fetch_addr, 24'h0001e8);
	endtask : t_flash

	task automatic t_converter();
		drive(11'h002);
		expect_vec(8'h8b, 1'b0);
		drive(11'h001);
		expect_vec(8'h8c, 1'b0);
	endtask : t_converter

	// lowest vector wins among several levels
	task automatic t_priority();
		drive(11'h7ff);
		expect_vec(8'h26, 1'b1);
		drive(11'h07f);
		expect_vec(8'h41, 1'b1);
	endtask : t_priority

	// reset in mid-run clears the offered vector at once
	task automatic t_reset();
		drive(11'h004);
		@(posedge clk);
		arst_n <= 1'b0;
		#1;
		check("reset vec_out", 32'(vec_out), 32'h0);
		@(posedge clk);
		arst_n <= 1'b1;
		drive(11'h000);
		check("after reset", vec_out.valid, 1'b0);
	endtask : t_reset

	// ************************************************************
	// verdict, watchdog, main sequence
	// ************************************************************
	task automatic give_verdict();
		$display("errors %0d checks %0d", error_cnt, n_checks);
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	// the tests need some 70 cycles; far more means a hang
	initial
	begin
		#(40 * 4000);
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		error_cnt = 0;
		n_checks  = 0;
		arst_n    = 1'b0;
		req       = '0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		t_idle();
		t_pulse();
		t_capture();
		t_flash();
		t_converter();
		t_priority();
		t_reset();
		give_verdict();
	end
endmodule : testbench
